// ==== src/zlt_pkg.sv ====
package zlt_pkg;
  // register indices (parameter index space)
  localparam logic [10:0] IDX_MF_CONFIG   = 11'h079;
  localparam logic [10:0] IDX_PROCESS_INPUT_DATA        = 11'h1e1;
  localparam logic [10:0] IDX_SEL_A       = 11'h439;
  localparam logic [10:0] IDX_SEL_B       = 11'h43a;
  localparam logic [10:0] IDX_COMB_A      = 11'h43b;
  localparam logic [10:0] IDX_COMB_B      = 11'h43c;
  localparam logic [10:0] IDX_MODE_A      = 11'h43d;
  localparam logic [10:0] IDX_MODE_B      = 11'h43e;
  localparam logic [10:0] IDX_TIME_A      = 11'h43f;
  localparam logic [10:0] IDX_TIME_B      = 11'h440;
  localparam logic [10:0] IDX_INV_A       = 11'h441;
  localparam logic [10:0] IDX_INV_B       = 11'h442;
  localparam logic [10:0] IDX_INV_EXT     = 11'h445;

  // selector codes: 0..3 zone results, 4 external input
  localparam logic [7:0]  SEL_EXT         = 8'h04;
  // combine codes
  localparam logic [7:0]  COMB_AND        = 8'h00;
  localparam logic [7:0]  COMB_OR         = 8'h01;
  // delay mode codes
  localparam logic [7:0]  MODE_DIRECT     = 8'h00;
  localparam logic [7:0]  MODE_ON_DELAY   = 8'h01;
  localparam logic [7:0]  MODE_OFF_DELAY  = 8'h02;
  localparam logic [7:0]  MODE_ON_OFF     = 8'h03;
  // multi-function pin codes
  localparam logic [7:0]  MF_OUTPUT_TWO   = 8'h00;
  localparam logic [7:0]  MF_EXT_INPUT    = 8'h01;
  localparam logic [7:0]  MF_HOLD         = 8'h02;
  localparam logic [7:0]  MF_TEACH        = 8'h03;
  localparam logic [7:0]  MF_ALARM        = 8'h04;

  // reset values
  localparam logic [7:0]  RST_MF_CONFIG   = 8'h00;
  localparam logic [7:0]  RST_SEL_A       = 8'h00;
  localparam logic [7:0]  RST_SEL_B       = 8'h01;
  localparam logic [7:0]  RST_COMB        = 8'h01;
  localparam logic [7:0]  RST_MODE        = 8'h00;
  localparam logic [15:0] RST_TIME        = 16'h0000;
  localparam logic [7:0]  RST_INV         = 8'h00;

  // process input data bit positions
  localparam int          PD_OUT_ONE      = 0;
  localparam int          PD_OUT_TWO      = 1;
  localparam int          PD_ZONE_LSB     = 2;

  // timing
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          MS_PER_S        = 1000;
  localparam int          CYC_PER_MS      = CLK_HZ / MS_PER_S;
endpackage

// ==== src/zlt_delay.sv ====
`timescale 1ns/1ps
module zlt_delay #(
  parameter int          CYC_PER_MS = 100000
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        din,
  input  wire logic [7:0]  mode,
  input  wire logic [15:0] time_ms,
  output logic             dout
);
  // ----------------------------------------
  // millisecond tick and delay counter
  // ----------------------------------------
  logic [16:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic        out_q, out_d;
  logic        tick;
  logic        delay_rise;
  logic        delay_fall;

  assign tick = (pre_q == 17'(CYC_PER_MS - 1));

  always_comb begin
    delay_rise = (mode == zlt_pkg::MODE_ON_DELAY) || (mode == zlt_pkg::MODE_ON_OFF);
    delay_fall = (mode == zlt_pkg::MODE_OFF_DELAY) || (mode == zlt_pkg::MODE_ON_OFF);
    pre_d = tick ? 17'h0 : pre_q + 17'h1;
    cnt_d = cnt_q;
    out_d = out_q;
    if (din == out_q) begin
      // R18 cancel pending change
      cnt_d = 16'h0;
      pre_d = 17'h0;
    end else if ((din && !delay_rise) || (!din && !delay_fall) || time_ms == 16'h0) begin
      out_d = din;
      cnt_d = 16'h0;
    // R3 on/off delay
    end else if (tick) begin
      // R4 time in ms
      if (cnt_q + 16'h1 >= time_ms) begin
        out_d = din;
        cnt_d = 16'h0;
      end else begin
        cnt_d = cnt_q + 16'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pre_q <= 17'h0;
      cnt_q <= 16'h0;
      out_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// ==== src/zlt_top.sv ====
// Operation
// (R1) each selector picks one of four zone results or the external input
// (R2) combine selector a and b with and or or per channel
// (R3) each timer applies direct, on-delay or off-delay mode
// (R4) each timer delay set in milliseconds by its own time register
// (R5) enabled inverter inverts the timer result before the output
// (R6) inversion follows the timer; timer behaviour unchanged
// (R7) output one drives the shared pin unless that pin carries the link
// (R8) multi-function pin: output two, input, hold, teach or alarm
// (R9) multi-function pin as input becomes a selector source
// (R10) while hold is high interrupted beams stay latched
// (R11) during hold a beam only goes from 0 to 1
// (R12) hold low releases latching; data follow live beams
// (R13) multi-function pin in teach mode starts a teach-in
// (R14) alarm mode outputs masked diagnostic conditions on the pin
// (R15) optional inverter on the external input before the selectors
// (R16) multi-function pin configuration set through one parameter index
// (R17) report outputs and zones; settings at consecutive indices (code puts the external input inverter at 0x445, after a gap from 0x442)
// (R18) input returning before expiry cancels the pending change
`timescale 1ns/1ps
module zlt_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // zone results and beams from the evaluation
  input  wire logic [3:0]  zone_state,
  input  wire logic [7:0]  beam_live,
  output logic [7:0]       beam_report,
  // diagnostic conditions and alarm mask
  input  wire logic [7:0]  diag_status,
  input  wire logic [7:0]  diag_mask,
  // parameter access
  input  wire logic        par_wr,
  input  wire logic [10:0] par_index,
  input  wire logic [15:0] par_wdata,
  output logic [15:0]      par_rdata,
  // shared pin one
  input  wire logic        link_active,
  output logic             switched_output_one,
  output logic             switched_output_one_oe,
  // multi-function pin
  input  wire logic        multi_function_pin_in,
  output logic             multi_function_pin_out,
  output logic             multi_function_pin_oe,
  output logic             teach_start
);
  // ----------------------------------------
  // settings registers
  // ----------------------------------------
  logic [7:0]  mf_cfg_q, mf_cfg_d;
  logic [7:0]  sel_a_q, sel_a_d, sel_b_q, sel_b_d;
  logic [7:0]  comb_a_q, comb_a_d, comb_b_q, comb_b_d;
  logic [7:0]  mode_a_q, mode_a_d, mode_b_q, mode_b_d;
  logic [15:0] time_a_q, time_a_d, time_b_q, time_b_d;
  logic [7:0]  inv_a_q, inv_a_d, inv_b_q, inv_b_d;
  logic [7:0]  inv_ext_q, inv_ext_d;

  always_comb begin
    mf_cfg_d  = mf_cfg_q;
    sel_a_d   = sel_a_q;
    sel_b_d   = sel_b_q;
    comb_a_d  = comb_a_q;
    comb_b_d  = comb_b_q;
    mode_a_d  = mode_a_q;
    mode_b_d  = mode_b_q;
    time_a_d  = time_a_q;
    time_b_d  = time_b_q;
    inv_a_d   = inv_a_q;
    inv_b_d   = inv_b_q;
    inv_ext_d = inv_ext_q;
    if (par_wr) begin
      unique case (par_index)
        // R16 pin configuration
        zlt_pkg::IDX_MF_CONFIG: mf_cfg_d  = par_wdata[7:0];
        // R17 consecutive settings up to inv b; external inverter at 0x445 after a gap
        zlt_pkg::IDX_SEL_A:     sel_a_d   = par_wdata[7:0];
        zlt_pkg::IDX_SEL_B:     sel_b_d   = par_wdata[7:0];
        zlt_pkg::IDX_COMB_A:    comb_a_d  = par_wdata[7:0];
        zlt_pkg::IDX_COMB_B:    comb_b_d  = par_wdata[7:0];
        zlt_pkg::IDX_MODE_A:    mode_a_d  = par_wdata[7:0];
        zlt_pkg::IDX_MODE_B:    mode_b_d  = par_wdata[7:0];
        zlt_pkg::IDX_TIME_A:    time_a_d  = par_wdata;
        zlt_pkg::IDX_TIME_B:    time_b_d  = par_wdata;
        zlt_pkg::IDX_INV_A:     inv_a_d   = par_wdata[7:0];
        zlt_pkg::IDX_INV_B:     inv_b_d   = par_wdata[7:0];
        zlt_pkg::IDX_INV_EXT:   inv_ext_d = par_wdata[7:0];
        // read-only and unmapped indices ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mf_cfg_q  <= zlt_pkg::RST_MF_CONFIG;
      sel_a_q   <= zlt_pkg::RST_SEL_A;
      sel_b_q   <= zlt_pkg::RST_SEL_B;
      comb_a_q  <= zlt_pkg::RST_COMB;
      comb_b_q  <= zlt_pkg::RST_COMB;
      mode_a_q  <= zlt_pkg::RST_MODE;
      mode_b_q  <= zlt_pkg::RST_MODE;
      time_a_q  <= zlt_pkg::RST_TIME;
      time_b_q  <= zlt_pkg::RST_TIME;
      inv_a_q   <= zlt_pkg::RST_INV;
      inv_b_q   <= zlt_pkg::RST_INV;
      inv_ext_q <= zlt_pkg::RST_INV;
    end else begin
      mf_cfg_q  <= mf_cfg_d;
      sel_a_q   <= sel_a_d;
      sel_b_q   <= sel_b_d;
      comb_a_q  <= comb_a_d;
      comb_b_q  <= comb_b_d;
      mode_a_q  <= mode_a_d;
      mode_b_q  <= mode_b_d;
      time_a_q  <= time_a_d;
      time_b_q  <= time_b_d;
      inv_a_q   <= inv_a_d;
      inv_b_q   <= inv_b_d;
      inv_ext_q <= inv_ext_d;
    end
  end

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // first stage is read only by the second
  logic mf_meta_q, mf_sync_q, mf_prev_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mf_meta_q <= 1'b0;
      mf_sync_q <= 1'b0;
      mf_prev_q <= 1'b0;
    end else begin
      mf_meta_q <= multi_function_pin_in;
      mf_sync_q <= mf_meta_q;
      mf_prev_q <= mf_sync_q;
    end
  end

  // ----------------------------------------
  // selectors and combine stage
  // ----------------------------------------
  logic ext_in;
  logic src_a, src_b;
  logic comb_a, comb_b;

  // a code above the external input reads as low
  function automatic logic pick(input logic [7:0] sel, input logic [3:0] zone, input logic ext);
    if (sel < zlt_pkg::SEL_EXT) begin
      pick = zone[sel[1:0]];
    end else if (sel == zlt_pkg::SEL_EXT) begin
      pick = ext;
    end else begin
      pick = 1'b0;
    end
  endfunction

  function automatic logic combine(input logic [7:0] fn, input logic a, input logic b);
    combine = (fn == zlt_pkg::COMB_AND) ? (a & b) : (a | b);
  endfunction

  always_comb begin
    // R9 pin as selectable source
    // R15 external input inverter
    ext_in = (mf_cfg_q == zlt_pkg::MF_EXT_INPUT) ? (mf_sync_q ^ inv_ext_q[0]) : 1'b0;
    // R1 source selection
    src_a  = pick(sel_a_q, zone_state, ext_in);
    src_b  = pick(sel_b_q, zone_state, ext_in);
    // R2 and or combine
    comb_a = combine(comb_a_q, src_a, src_b);
    comb_b = combine(comb_b_q, src_a, src_b);
  end

  // ----------------------------------------
  // delay timers and inverters
  // ----------------------------------------
  logic tmr_a, tmr_b;
  logic res_one, res_two;

  // R3 timer channel a
  zlt_delay #(
    .CYC_PER_MS (zlt_pkg::CYC_PER_MS)
  ) u_delay_a (
    .clock   (clock),
    .rst_n   (rst_n),
    .din     (comb_a),
    .mode    (mode_a_q),
    .time_ms (time_a_q),
    .dout    (tmr_a)
  );

  // R3 timer channel b
  zlt_delay #(
    .CYC_PER_MS (zlt_pkg::CYC_PER_MS)
  ) u_delay_b (
    .clock   (clock),
    .rst_n   (rst_n),
    .din     (comb_b),
    .mode    (mode_b_q),
    .time_ms (time_b_q),
    .dout    (tmr_b)
  );

  // R5 output inversion
  // R6 after the timer
  assign res_one = tmr_a ^ inv_a_q[0];
  assign res_two = tmr_b ^ inv_b_q[0];

  // ----------------------------------------
  // beam hold
  // ----------------------------------------
  logic       hold_on;
  logic [7:0] hold_q, hold_d;

  assign hold_on = (mf_cfg_q == zlt_pkg::MF_HOLD) && mf_sync_q;

  always_comb begin
    // R10 latch interrupted beams
    // R11 only 0 to 1
    // R12 release follows live
    hold_d = hold_on ? (hold_q | beam_live) : beam_live;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------
  // pin outputs and teach trigger
  // ----------------------------------------
  logic one_q, one_d, one_oe_q, one_oe_d;
  logic mf_out_q, mf_out_d, mf_oe_q, mf_oe_d;
  logic teach_q, teach_d;

  always_comb begin
    // R7 shared pin yields to link
    one_d    = link_active ? 1'b0 : res_one;
    one_oe_d = !link_active;
    // R8 pin function select
    unique case (mf_cfg_q)
      zlt_pkg::MF_OUTPUT_TWO: begin
        mf_out_d = res_two;
        mf_oe_d  = 1'b1;
      end
      zlt_pkg::MF_ALARM: begin
        // R14 masked alarm
        mf_out_d = |(diag_status & diag_mask);
        mf_oe_d  = 1'b1;
      end
      default: begin
        mf_out_d = 1'b0;
        mf_oe_d  = 1'b0;
      end
    endcase
    // R13 teach on rising edge
    teach_d = (mf_cfg_q == zlt_pkg::MF_TEACH) && mf_sync_q && !mf_prev_q;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      one_q    <= 1'b0;
      one_oe_q <= 1'b0;
      mf_out_q <= 1'b0;
      mf_oe_q  <= 1'b0;
      teach_q  <= 1'b0;
    end else begin
      one_q    <= one_d;
      one_oe_q <= one_oe_d;
      mf_out_q <= mf_out_d;
      mf_oe_q  <= mf_oe_d;
      teach_q  <= teach_d;
    end
  end

  assign switched_output_one    = one_q;
  assign switched_output_one_oe = one_oe_q;
  assign multi_function_pin_out = mf_out_q;
  assign multi_function_pin_oe  = mf_oe_q;
  assign teach_start            = teach_q;
  assign beam_report            = hold_q;

  // ----------------------------------------
  // parameter read
  // ----------------------------------------
  logic [15:0] rdata_d, rdata_q;
  logic [7:0]  process_input_data;

  always_comb begin
    // R17 process input data
    process_input_data = 8'h00;
    process_input_data[zlt_pkg::PD_OUT_ONE] = res_one;
    process_input_data[zlt_pkg::PD_OUT_TWO] = res_two;
    process_input_data[zlt_pkg::PD_ZONE_LSB +: 4] = zone_state;
    unique case (par_index)
      zlt_pkg::IDX_MF_CONFIG: rdata_d = {8'h00, mf_cfg_q};
      zlt_pkg::IDX_PROCESS_INPUT_DATA:      rdata_d = {8'h00, process_input_data};
      zlt_pkg::IDX_SEL_A:     rdata_d = {8'h00, sel_a_q};
      zlt_pkg::IDX_SEL_B:     rdata_d = {8'h00, sel_b_q};
      zlt_pkg::IDX_COMB_A:    rdata_d = {8'h00, comb_a_q};
      zlt_pkg::IDX_COMB_B:    rdata_d = {8'h00, comb_b_q};
      zlt_pkg::IDX_MODE_A:    rdata_d = {8'h00, mode_a_q};
      zlt_pkg::IDX_MODE_B:    rdata_d = {8'h00, mode_b_q};
      zlt_pkg::IDX_TIME_A:    rdata_d = time_a_q;
      zlt_pkg::IDX_TIME_B:    rdata_d = time_b_q;
      zlt_pkg::IDX_INV_A:     rdata_d = {8'h00, inv_a_q};
      zlt_pkg::IDX_INV_B:     rdata_d = {8'h00, inv_b_q};
      zlt_pkg::IDX_INV_EXT:   rdata_d = {8'h00, inv_ext_q};
      default:                rdata_d = 16'h0000;
    endcase
  end

  // registered read: data lag the index by one cycle but leave the pins glitch free
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign par_rdata = rdata_q;
endmodule

// ==== verification/zlt_top_assertions.sv ====
`timescale 1ns/1ps
// ----------------
// port checks
// ----------------
module zlt_chk (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  beam_live,
  input wire logic [7:0]  beam_report,
  input wire logic [7:0]  diag_status,
  input wire logic [7:0]  diag_mask,
  input wire logic        par_wr,
  input wire logic [10:0] par_index,
  input wire logic [15:0] par_wdata,
  input wire logic [15:0] par_rdata,
  input wire logic        link_active,
  input wire logic        switched_output_one_oe,
  input wire logic        multi_function_pin_in,
  input wire logic        multi_function_pin_out,
  input wire logic        multi_function_pin_oe,
  input wire logic        teach_start
);
  logic [3:0] ph_q;
  logic       mf;
  logic       mf_q;
  logic [7:0] cf;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // pin history: covers the two-flop sync lag
  always_ff @(posedge clock) ph_q <= {ph_q[2:0], multi_function_pin_in};
  // read data lag one cycle: trust config after two quiet cycles on its index
  always_ff @(posedge clock) mf_q <= par_index == zlt_pkg::IDX_MF_CONFIG && !par_wr;
  assign mf = mf_q && par_index == zlt_pkg::IDX_MF_CONFIG && !par_wr;
  assign cf = par_rdata[7:0];
  property p_oe_off;
    link_active |=> !switched_output_one_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("pin one driven during link");
  property p_oe_on;
    $past(rst_n) && !link_active |=> switched_output_one_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin one not driven");
  property p_mf_oe;
    mf |=> multi_function_pin_oe == ($past(cf) == zlt_pkg::MF_OUTPUT_TWO || $past(cf) == zlt_pkg::MF_ALARM);
  endproperty
  a_mf_oe: assert property (p_mf_oe) else $error("pin drive enable wrong for mode");
  property p_teach;
    teach_start |-> ph_q[1] && ph_q[2] ##1 !teach_start;
  endproperty
  a_teach: assert property (p_teach) else $error("teach pulse without pin");
  property p_hold;
    mf && cf == zlt_pkg::MF_HOLD && &ph_q[2:0] |=> (~beam_report & $past(beam_report)) == 8'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("held beam dropped");
  property p_follow;
    mf && cf != zlt_pkg::MF_HOLD |=> beam_report == $past(beam_live);
  endproperty
  a_follow: assert property (p_follow) else $error("beams not following live");
  property p_alarm;
    mf && cf == zlt_pkg::MF_ALARM |=> multi_function_pin_out == |($past(diag_status) & $past(diag_mask));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm level wrong");
  property p_cfg_wr;
    par_wr && par_index == zlt_pkg::IDX_MF_CONFIG ##1 par_index == zlt_pkg::IDX_MF_CONFIG
      |=> {8'h00, cf} == ($past(par_wdata, 2) & 16'h00ff);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("pin config not stored");
endmodule

bind zlt_top zlt_chk i_chk (
  .clock(clock), .rst_n(rst_n), .beam_live(beam_live), .beam_report(beam_report),
  .diag_status(diag_status), .diag_mask(diag_mask), .par_wr(par_wr), .par_index(par_index),
  .par_wdata(par_wdata), .par_rdata(par_rdata), .link_active(link_active),
  .switched_output_one_oe(switched_output_one_oe), .multi_function_pin_in(multi_function_pin_in),
  .multi_function_pin_out(multi_function_pin_out), .multi_function_pin_oe(multi_function_pin_oe),
  .teach_start(teach_start)
);

// ==== verification/zlt_master.sv ====
`timescale 1ns/1ps
// ----------------
// link master and pin source
// ----------------
module zlt_master (
  input  wire logic [15:0] par_rdata,
  input  wire logic        clock,
  output logic             par_wr,
  output logic [10:0]      par_index,
  output logic [15:0]      par_wdata,
  output logic             link_active,
  output logic             ext_drv
);
  initial begin
    par_wr = 1'b0;
    par_index = 11'h000;
    par_wdata = 16'h0000;
    link_active = 1'b0;
    ext_drv = 1'b0;
  end
  task automatic wr(input logic [10:0] i, input logic [15:0] d);
    @(posedge clock);
    par_wr <= 1'b1;
    par_index <= i;
    par_wdata <= d;
    @(posedge clock);
    par_wr <= 1'b0;
    par_wdata <= ~d;
  endtask
  task automatic rd(input logic [10:0] i, output logic [15:0] d);
    @(posedge clock);
    par_index <= i;
    @(posedge clock);
    #1;
    d = par_rdata;
  endtask
  task automatic set_link(input logic b);
    @(posedge clock);
    link_active <= b;
  endtask
  task automatic pin(input logic b);
    @(posedge clock);
    ext_drv <= b;
  endtask
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
// ----------------
// bench
// ----------------
module tb;
  typedef struct packed {
    logic [7:0] sa;
    logic [7:0] sb;
    logic [7:0] cb;
    logic [3:0] z;
    logic       e;
  } zlt_row_s;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  zone_state = 4'h0;
  logic [7:0]  beam_live = 8'h00;
  logic [7:0]  diag_status = 8'h00;
  logic [7:0]  diag_mask = 8'h00;
  logic [7:0]  beam_report;
  logic        par_wr, link_active, ext_drv, mf_out, mf_oe, out1, oe1, teach, mf_wire;
  logic [10:0] par_index;
  logic [15:0] par_wdata, par_rdata, rd_v;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          k;
  zlt_row_s    rows [6] = '{
    '{8'h00, 8'h01, 8'h01, 4'h1, 1'b1}, '{8'h00, 8'h01, 8'h00, 4'h1, 1'b0},
    '{8'h02, 8'h03, 8'h00, 4'hc, 1'b1}, '{8'h02, 8'h03, 8'h00, 4'h4, 1'b0},
    '{8'h03, 8'h01, 8'h01, 4'h8, 1'b1}, '{8'h01, 8'h02, 8'h00, 4'h2, 1'b0}};
  logic [26:0] rv [10] = '{
    {11'h079, 16'h0000}, {11'h439, 16'h0000}, {11'h43a, 16'h0001}, {11'h43b, 16'h0001},
    {11'h43c, 16'h0001}, {11'h43d, 16'h0000}, {11'h43f, 16'h0000}, {11'h441, 16'h0000},
    {11'h445, 16'h0000}, {11'h7ff, 16'h0000}};

  always #5 clock = ~clock;
  // shared pin: whoever is enabled sets the level
  assign mf_wire = mf_oe ? mf_out : ext_drv;

  zlt_top i_dut (
    .clock(clock), .rst_n(rst_n), .zone_state(zone_state), .beam_live(beam_live),
    .beam_report(beam_report), .diag_status(diag_status), .diag_mask(diag_mask),
    .par_wr(par_wr), .par_index(par_index), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .link_active(link_active), .switched_output_one(out1), .switched_output_one_oe(oe1),
    .multi_function_pin_in(mf_wire), .multi_function_pin_out(mf_out),
    .multi_function_pin_oe(mf_oe), .teach_start(teach));
  zlt_master i_mst (
    .clock(clock), .par_rdata(par_rdata), .par_wr(par_wr), .par_index(par_index),
    .par_wdata(par_wdata), .link_active(link_active), .ext_drv(ext_drv));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cfg(input logic [10:0] i, input logic [7:0] d);
    i_mst.wr(i, {8'h00, d});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 102000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (k = 0; k < 6; k++) begin
      cfg(zlt_pkg::IDX_SEL_A, rows[k].sa);
      cfg(zlt_pkg::IDX_SEL_B, rows[k].sb);
      cfg(zlt_pkg::IDX_COMB_A, rows[k].cb);
      zone_state <= rows[k].z;
      w(4);
      chk(16'(out1), 16'(rows[k].e));
    end
    cfg(zlt_pkg::IDX_INV_A, 8'h01);
    w(4);
    chk(16'(out1), 16'h0001);
    i_mst.rd(zlt_pkg::IDX_PROCESS_INPUT_DATA, rd_v);
    chk(16'(rd_v[5:2]), 16'h0002);
    cfg(zlt_pkg::IDX_INV_A, 8'h00);
    cfg(zlt_pkg::IDX_MF_CONFIG, zlt_pkg::MF_EXT_INPUT);
    cfg(zlt_pkg::IDX_SEL_A, zlt_pkg::SEL_EXT);
    cfg(zlt_pkg::IDX_COMB_A, zlt_pkg::COMB_OR);
    zone_state <= 4'h0;
    i_mst.pin(1'b1);
    w(6);
    chk(16'(out1), 16'h0001);
    cfg(zlt_pkg::IDX_INV_EXT, 8'h01);
    w(6);
    chk(16'(out1), 16'h0000);
    i_mst.set_link(1'b1);
    w(3);
    chk(16'(oe1), 16'h0000);
    i_mst.set_link(1'b0);
    w(3);
    chk(16'(oe1), 16'h0001);
    cfg(zlt_pkg::IDX_MF_CONFIG, zlt_pkg::MF_HOLD);
    @(posedge clock);
    beam_live <= 8'h05;
    w(3);
    @(posedge clock);
    beam_live <= 8'h0a;
    w(3);
    chk(16'(beam_report), 16'h000f);
    i_mst.pin(1'b0);
    w(5);
    chk(16'(beam_report), 16'h000a);
    cfg(zlt_pkg::IDX_MF_CONFIG, zlt_pkg::MF_TEACH);
    k = 0;
    i_mst.pin(1'b1);
    repeat (8) begin
      w(1);
      if (teach === 1'b1) k++;
    end
    chk(16'(k), 16'h0001);
    cfg(zlt_pkg::IDX_MF_CONFIG, zlt_pkg::MF_ALARM);
    diag_status <= 8'h12;
    diag_mask <= 8'h02;
    w(3);
    chk(16'({mf_out, mf_oe}), 16'h0003);
    @(posedge clock);
    diag_mask <= 8'h01;
    w(3);
    chk(16'(mf_out), 16'h0000);
    cfg(zlt_pkg::IDX_MF_CONFIG, zlt_pkg::MF_OUTPUT_TWO);
    zone_state <= 4'h4;
    w(4);
    chk(16'({mf_out, mf_oe}), 16'h0003);
    cfg(zlt_pkg::IDX_SEL_A, 8'h00);
    cfg(zlt_pkg::IDX_SEL_B, 8'h00);
    cfg(zlt_pkg::IDX_MODE_A, zlt_pkg::MODE_ON_DELAY);
    cfg(zlt_pkg::IDX_MODE_B, zlt_pkg::MODE_OFF_DELAY);
    i_mst.wr(zlt_pkg::IDX_TIME_B, 16'h0001);
    i_mst.wr(zlt_pkg::IDX_TIME_A, 16'h0001);
    cfg(zlt_pkg::IDX_INV_A, 8'h01);
    zone_state <= 4'h0;
    w(4);
    chk(16'(out1), 16'h0001);
    // short pulse first: an uncancelled count would fire early
    @(posedge clock);
    zone_state <= 4'h1;
    w(500);
    @(posedge clock);
    zone_state <= 4'h0;
    w(10);
    chk(16'(mf_out), 16'h0001);
    @(posedge clock);
    zone_state <= 4'h1;
    w(99990);
    chk(16'(out1), 16'h0001);
    w(20);
    chk(16'(out1), 16'h0000);
    @(posedge clock);
    rst_n <= 1'b0;
    w(2);
    @(posedge clock);
    rst_n <= 1'b1;
    for (k = 0; k < 10; k++) begin
      i_mst.rd(rv[k][26:16], rd_v);
      chk(rd_v, rv[k][15:0]);
    end
    give_verdict();
  end
endmodule
